// *** logic/tfhp_top.sv ***
// Host port of a tape formatter: unit select, command latch, write data, status
module tfhp_top (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic INITIATE_N_I,
  input wire logic DIR_REVERSE_N_I,
  input wire logic WRITE_SELECT_N_I,
  input wire logic FILE_MARK_SELECT_N_I,
  input wire logic EDIT_SELECT_N_I,
  input wire logic ERASE_SELECT_N_I,
  input wire logic FAST_SPEED_REQ_N_I,
  input wire logic LONG_GAP_REQ_N_I,
  input wire logic REWIND_PULSE_N_I,
  input wire logic UNLOAD_PULSE_N_I,
  input wire logic LOAD_ONLINE_PULSE_N_I,
  input wire logic LAST_CHAR_FLAG_N_I,
  input wire logic CHAIN_ENABLE_N_I,
  input wire logic UNIT_ADDR_HIGH_N_I,
  input wire logic UNIT_ADDR_MID_N_I,
  input wire logic UNIT_ADDR_LOW_N_I,
  input wire logic WRITE_PARITY_N_I,
  input wire logic [7:0] WRITE_BYTE_LINES_N_I,
  input wire logic [5:0] PIN_LVL_I,
  output logic [5:0] PIN_DRV_O,
  output logic [5:0] PIN_OE_O,
  input wire logic TAPE_LOADED_I,
  input wire logic AT_LOAD_POINT_I,
  input wire logic LOAD_DONE_I,
  input wire logic UNLOAD_DONE_I,
  input wire logic MOTION_STOPPED_I,
  input wire logic INCH_TICK_I,
  input wire logic CHAR_TICK_I,
  input wire logic BLOCK_DONE_I,
  input wire logic [5:0] FAULT_EVT_I,
  input wire logic CORR_EVT_I,
  input wire logic [3:0] DROP_TRACKS_I,
  input wire logic BLANK_25FT_I,
  output logic MOTION_RUN_O,
  output logic MOTION_REV_O,
  output logic FAST_MODE_O,
  output logic REPOSITION_O,
  output logic LONG_GAP_O,
  output logic REWIND_O,
  output logic UNLOAD_O,
  output logic LOAD_O,
  output logic [4:0] CMD_O,
  output logic [7:0] WCHAR_O,
  output logic WPAR_O,
  output logic WCHAR_VLD_O
);
  logic [tfhp_pkg::SYNC_W-1:0] s;
  logic [tfhp_pkg::SYNC_W-1:0] prev_q;
  logic [15:0] cfg_q;
  logic [31:0] rdata_q;
  tfhp_pkg::tfhp_run_t st_q;
  tfhp_pkg::tfhp_mech_t mech_q;
  logic [4:0] cmd_q;
  logic fby_q, dby_q, write_char_strobe_q, her_q, fast_q, repos_q, gap_q, run_q;
  logic [7:0] gap_cnt_q;
  logic [1:0] inch_q;
  logic [7:0] err_cnt_q;
  logic sel, en, online, init_fall, accept, wr_done, last_char, writing, fault;
  tfhp_wr_if w ();

  // Commands that move data over the write lines, one strobe per character
  function automatic logic takes_chars(input logic [4:0] c);
    return c[tfhp_pkg::CB_WRT] && !c[tfhp_pkg::CB_WFM];
  endfunction
  function automatic logic is_write(input logic [4:0] c);
    return c[tfhp_pkg::CB_WRT];
  endfunction

  // Pins are low true; inversion makes an open (pulled high) line read false
  tfhp_sync #(.W(tfhp_pkg::SYNC_W)) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(~{WRITE_BYTE_LINES_N_I, WRITE_PARITY_N_I, UNIT_ADDR_HIGH_N_I, UNIT_ADDR_MID_N_I,
      UNIT_ADDR_LOW_N_I, CHAIN_ENABLE_N_I, LAST_CHAR_FLAG_N_I, LOAD_ONLINE_PULSE_N_I,
      UNLOAD_PULSE_N_I, REWIND_PULSE_N_I, LONG_GAP_REQ_N_I, FAST_SPEED_REQ_N_I,
      DIR_REVERSE_N_I, WRITE_SELECT_N_I, FILE_MARK_SELECT_N_I, EDIT_SELECT_N_I,
      ERASE_SELECT_N_I, INITIATE_N_I}),
    .q_o(s)
  );

  tfhp_wr_path u_wr (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .w(w.path)
  );

  // Edge history of the synchronised lines
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      prev_q <= '0;
    end else begin
      prev_q <= s;
    end
  end

  // Select and enable decode
  assign sel = s[tfhp_pkg::PI_ADDR_LSB +: 3] == cfg_q[tfhp_pkg::CFG_ADDR_LSB +: 3];
  assign en = s[tfhp_pkg::PI_CHEN] ^ cfg_q[tfhp_pkg::CFG_POL_BIT];
  assign online = mech_q == tfhp_pkg::M_ONLINE;
  assign init_fall = prev_q[tfhp_pkg::PI_INIT] && !s[tfhp_pkg::PI_INIT];
  assign accept = init_fall && sel && en && online;
  assign last_char = s[tfhp_pkg::PI_LAST];
  assign writing = st_q == tfhp_pkg::S_DATA && takes_chars(cmd_q);
  assign wr_done = write_char_strobe_q && last_char;

  // Write strobe: one per character period while a character command runs
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      write_char_strobe_q <= 1'b0;
    end else begin
      write_char_strobe_q <= writing && CHAR_TICK_I && !wr_done && en;
    end
  end
  assign w.strobe = writing && CHAR_TICK_I && !wr_done && en;
  assign w.raw_byte = s[tfhp_pkg::PI_DATA_LSB +: 8];
  assign w.host_par = s[tfhp_pkg::PI_PAR];
  assign w.pchk_en = cfg_q[tfhp_pkg::CFG_PCHK_BIT];

  // Command execution; disable or leaving line ends the command and stops tape
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= tfhp_pkg::S_IDLE;
      cmd_q <= tfhp_pkg::CMD_READ_FWD;
      fby_q <= 1'b0;
      dby_q <= 1'b0;
      run_q <= 1'b0;
      repos_q <= 1'b0;
      inch_q <= 2'h0;
    end else begin
      repos_q <= 1'b0;
      if ((!en || !online) && st_q != tfhp_pkg::S_IDLE) begin
        st_q <= tfhp_pkg::S_STOP;
        dby_q <= 1'b0;
        run_q <= 1'b0;
        if (st_q == tfhp_pkg::S_STOP && MOTION_STOPPED_I) begin
          st_q <= tfhp_pkg::S_IDLE;
          fby_q <= 1'b0;
        end
      end else if (accept && st_q != tfhp_pkg::S_DATA && st_q != tfhp_pkg::S_STOP) begin
        cmd_q <= s[tfhp_pkg::PI_CMD_LSB +: 5];
        fby_q <= 1'b1;
        dby_q <= 1'b1;
        run_q <= 1'b1;
        st_q <= tfhp_pkg::S_DATA;
      end else begin
        case (st_q)
          tfhp_pkg::S_IDLE: begin
            run_q <= 1'b0;
          end
          tfhp_pkg::S_DATA: begin
            if (takes_chars(cmd_q) ? wr_done : BLOCK_DONE_I) begin
              dby_q <= 1'b0;
              if (fast_q && cfg_q[tfhp_pkg::CFG_FBYDBY_BIT]) begin
                fby_q <= 1'b0;
              end
              st_q <= tfhp_pkg::S_WINDOW;
            end
          end
          tfhp_pkg::S_WINDOW: begin
            if (!gap_q && (CHAR_TICK_I || !fast_q)) begin
              inch_q <= 2'h0;
              if (fast_q && is_write(cmd_q) && s[tfhp_pkg::PI_INIT]) begin
                st_q <= tfhp_pkg::S_EXTEND;
              end else begin
                repos_q <= fast_q;
                run_q <= 1'b0;
                st_q <= tfhp_pkg::S_STOP;
              end
            end
          end
          tfhp_pkg::S_EXTEND: begin
            if (INCH_TICK_I) begin
              inch_q <= inch_q + 2'h1;
              if (inch_q + 2'h1 >= tfhp_pkg::EXT_INCHES) begin
                repos_q <= 1'b1;
                run_q <= 1'b0;
                st_q <= tfhp_pkg::S_STOP;
              end
            end
          end
          tfhp_pkg::S_STOP: begin
            run_q <= 1'b0;
            if (MOTION_STOPPED_I) begin
              fby_q <= 1'b0;
              st_q <= tfhp_pkg::S_IDLE;
            end
          end
          default: begin
            st_q <= tfhp_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // Long gap: counts character periods after a write record, cut by a new command
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      gap_q <= 1'b0;
      gap_cnt_q <= 8'h00;
    end else if (accept || !en || st_q == tfhp_pkg::S_STOP) begin
      gap_q <= 1'b0;
      gap_cnt_q <= 8'h00;
    end else if (st_q == tfhp_pkg::S_DATA && is_write(cmd_q) && dby_q &&
                 s[tfhp_pkg::PI_LGAP]) begin
      gap_q <= 1'b1;
      gap_cnt_q <= 8'h00;
    end else if (gap_q && CHAR_TICK_I && st_q != tfhp_pkg::S_DATA) begin
      gap_cnt_q <= gap_cnt_q + 8'h01;
      if (gap_cnt_q + 8'h01 >= cfg_q[tfhp_pkg::CFG_LGAP_LSB +: 8]) begin
        gap_q <= 1'b0;
      end
    end
  end

  // Fast mode follows the request on the selected on-line unit
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fast_q <= 1'b0;
    end else begin
      fast_q <= s[tfhp_pkg::PI_FAST] && sel && online && en;
    end
  end

  // Transport handling: rewind and unload run apart from data transfers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mech_q <= tfhp_pkg::M_OFFLINE;
    end else begin
      case (mech_q)
        tfhp_pkg::M_OFFLINE: begin
          if (s[tfhp_pkg::PI_LOAD] && !prev_q[tfhp_pkg::PI_LOAD] && sel && en) begin
            mech_q <= TAPE_LOADED_I ? tfhp_pkg::M_ONLINE : tfhp_pkg::M_LOADING;
          end
        end
        tfhp_pkg::M_LOADING: begin
          if (LOAD_DONE_I) begin
            mech_q <= tfhp_pkg::M_ONLINE;
          end
        end
        tfhp_pkg::M_ONLINE: begin
          if (s[tfhp_pkg::PI_UNL] && !prev_q[tfhp_pkg::PI_UNL] && sel && en) begin
            mech_q <= tfhp_pkg::M_UNL_RW;
          end else if (s[tfhp_pkg::PI_REW] && !prev_q[tfhp_pkg::PI_REW] && sel && en &&
                       st_q == tfhp_pkg::S_IDLE) begin
            mech_q <= tfhp_pkg::M_REWIND;
          end
        end
        tfhp_pkg::M_REWIND: begin
          if (AT_LOAD_POINT_I) begin
            mech_q <= tfhp_pkg::M_ONLINE;
          end
        end
        tfhp_pkg::M_UNL_RW: begin
          if (AT_LOAD_POINT_I) begin
            mech_q <= tfhp_pkg::M_UNLOADING;
          end
        end
        tfhp_pkg::M_UNLOADING: begin
          if (UNLOAD_DONE_I) begin
            mech_q <= tfhp_pkg::M_OFFLINE;
          end
        end
        default: begin
          mech_q <= tfhp_pkg::M_OFFLINE;
        end
      endcase
    end
  end

  // Hard fault: real-time pulse, or held from first error until next command or disable
  assign fault = |FAULT_EVT_I || w.par_err ||
    (is_write(cmd_q) && DROP_TRACKS_I >= tfhp_pkg::DROP_WR_MIN) ||
    (!is_write(cmd_q) && DROP_TRACKS_I >= tfhp_pkg::DROP_RD_MIN) ||
    (cfg_q[tfhp_pkg::CFG_GAP25_BIT] && !is_write(cmd_q) && BLANK_25FT_I);
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      her_q <= 1'b0;
      err_cnt_q <= 8'h00;
    end else begin
      if (!cfg_q[tfhp_pkg::CFG_HERCAP_BIT]) begin
        her_q <= fault && dby_q;
      end else if (dby_q && (fault || CORR_EVT_I)) begin
        her_q <= 1'b1;
      end else if (accept || !en) begin
        her_q <= 1'b0;
      end
      if (fault && dby_q && err_cnt_q != 8'hff) begin
        err_cnt_q <= err_cnt_q + 8'h01;
      end
    end
  end

  // Register port; the setup word steers select, polarity and fault modes
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_q <= tfhp_pkg::CFG_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (WR_I && ADDR_I == tfhp_pkg::CFG_OFS) begin
        cfg_q <= WDATA_I[15:0];
      end
      rdata_q <= 32'h0000_0000;
      if (RD_I) begin
        case (ADDR_I)
          tfhp_pkg::CFG_OFS: rdata_q <= {16'h0000, cfg_q};
          tfhp_pkg::STAT_OFS: rdata_q <= {7'h00, PIN_LVL_I, mech_q, st_q, err_cnt_q};
          tfhp_pkg::CMD_OFS: rdata_q <= {27'h0000000, cmd_q};
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Output flops; an output enable pulls its line low, i.e. true
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PIN_OE_O <= 6'h00;
      PIN_DRV_O <= 6'h00;
      {MOTION_RUN_O, MOTION_REV_O, FAST_MODE_O, REPOSITION_O, LONG_GAP_O} <= 5'h00;
      {REWIND_O, UNLOAD_O, LOAD_O} <= 3'h0;
      CMD_O <= 5'h00;
    end else begin
      PIN_DRV_O <= 6'h00;
      PIN_OE_O <= {mech_q == tfhp_pkg::M_ONLINE || mech_q == tfhp_pkg::M_REWIND,
        online && st_q == tfhp_pkg::S_IDLE, write_char_strobe_q, her_q, dby_q, fby_q};
      MOTION_RUN_O <= run_q || gap_q;
      MOTION_REV_O <= cmd_q[tfhp_pkg::CB_REV];
      FAST_MODE_O <= fast_q;
      REPOSITION_O <= repos_q;
      LONG_GAP_O <= gap_q;
      REWIND_O <= mech_q == tfhp_pkg::M_REWIND || mech_q == tfhp_pkg::M_UNL_RW;
      UNLOAD_O <= mech_q == tfhp_pkg::M_UNLOADING;
      LOAD_O <= mech_q == tfhp_pkg::M_LOADING;
      CMD_O <= cmd_q;
    end
  end
  assign RDATA_O = rdata_q;
  assign WCHAR_O = w.char_q;
  assign WPAR_O = w.par_q;
  assign WCHAR_VLD_O = w.vld;

  fby_rise_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    accept && st_q == tfhp_pkg::S_IDLE |=> fby_q && dby_q ##1 PIN_OE_O[tfhp_pkg::PO_FBY])
    else $error("busy did not rise after initiate");
  cmd_latch_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    accept && st_q == tfhp_pkg::S_IDLE |=> cmd_q == $past(s[5:1]))
    else $error("command not latched");
  rew_idle_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    mech_q == tfhp_pkg::M_REWIND |=> !PIN_OE_O[tfhp_pkg::PO_RDY] && !fby_q)
    else $error("ready or busy during rewind");
  ext_repos_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    st_q == tfhp_pkg::S_EXTEND && INCH_TICK_I && !accept && en && online
    |=> repos_q && st_q == tfhp_pkg::S_STOP) else $error("no reposition after one inch");
  fast_mode_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s[tfhp_pkg::PI_FAST] && sel && online && en |=> ##1 FAST_MODE_O)
    else $error("fast mode not taken");
  chain_off_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !en && st_q != tfhp_pkg::S_IDLE |=> !dby_q && !run_q) else $error("disable ignored");
  unload_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    online && s[tfhp_pkg::PI_UNL] && !prev_q[tfhp_pkg::PI_UNL] && sel && en
    |=> ##1 !PIN_OE_O[tfhp_pkg::PO_ONL]) else $error("unit stayed on line");
  drop_wr_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !cfg_q[tfhp_pkg::CFG_HERCAP_BIT] && dby_q && is_write(cmd_q) &&
    DROP_TRACKS_I >= tfhp_pkg::DROP_WR_MIN |=> her_q) else $error("dropout not flagged");
  gap_cut_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    gap_q && accept |=> !gap_q) else $error("long gap not cut by command");
endmodule

// *** pkg/tfhp_pkg.sv ***
// Constants, field layout and state types of the tape formatter host port
package tfhp_pkg;
  // Register map, byte addresses
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CMD_OFS = 8'h08;
  // Configuration fields
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_POL_BIT = 3;
  localparam int CFG_FBYDBY_BIT = 4;
  localparam int CFG_HERCAP_BIT = 5;
  localparam int CFG_GAP25_BIT = 6;
  localparam int CFG_PCHK_BIT = 7;
  localparam int CFG_LGAP_LSB = 8;
  localparam logic [15:0] CFG_RST = 16'h1000;
  // Synchronised host line positions
  localparam int SYNC_W = 25;
  localparam int PI_INIT = 0;
  localparam int PI_CMD_LSB = 1;
  localparam int PI_FAST = 6;
  localparam int PI_LGAP = 7;
  localparam int PI_REW = 8;
  localparam int PI_UNL = 9;
  localparam int PI_LOAD = 10;
  localparam int PI_LAST = 11;
  localparam int PI_CHEN = 12;
  localparam int PI_ADDR_LSB = 13;
  localparam int PI_PAR = 16;
  localparam int PI_DATA_LSB = 17;
  // Command word {reverse, write, file mark, edit, erase}
  localparam int CB_REV = 4;
  localparam int CB_WRT = 3;
  localparam int CB_WFM = 2;
  localparam int CB_EDT = 1;
  localparam int CB_ERS = 0;
  localparam logic [4:0] CMD_READ_FWD = 5'h00;
  localparam logic [4:0] CMD_WRITE = 5'h08;
  localparam logic [4:0] CMD_WFM = 5'h0c;
  localparam logic [4:0] CMD_ERASE_VAR = 5'h09;
  // Fault thresholds and limits
  localparam int FAULT_W = 6;
  localparam logic [3:0] DROP_WR_MIN = 4'h2;
  localparam logic [3:0] DROP_RD_MIN = 4'h3;
  localparam logic [1:0] EXT_INCHES = 2'h1;
  // Open collector output pins
  localparam int PO_W = 6;
  localparam int PO_FBY = 0;
  localparam int PO_DBY = 1;
  localparam int PO_HER = 2;
  localparam int PO_WRITE_CHAR_STROBE = 3;
  localparam int PO_RDY = 4;
  localparam int PO_ONL = 5;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_DATA = 5'h02, S_WINDOW = 5'h04, S_EXTEND = 5'h08, S_STOP = 5'h10
  } tfhp_run_t;
  typedef enum logic [5:0] {
    M_OFFLINE = 6'h01, M_LOADING = 6'h02, M_ONLINE = 6'h04,
    M_REWIND = 6'h08, M_UNL_RW = 6'h10, M_UNLOADING = 6'h20
  } tfhp_mech_t;
endpackage

// *** pkg/tfhp_wr_if.sv ***
// Carrier between the port control and the write character path
interface tfhp_wr_if;
  logic strobe;
  logic [7:0] raw_byte;
  logic host_par;
  logic pchk_en;
  logic [7:0] char_q;
  logic par_q;
  logic par_err;
  logic vld;
  modport ctl (output strobe, raw_byte, host_par, pchk_en, input char_q, par_q, par_err, vld);
  modport path (input strobe, raw_byte, host_par, pchk_en, output char_q, par_q, par_err, vld);
endinterface

// *** logic/tfhp_sync.sv ***
// Two flip-flop synchroniser for a vector of host lines
module tfhp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  genvar g;
  // Each line gets its own pair; the first stage feeds only the second
  for (g = 0; g < W; g++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= d_i[g];
        sync_q <= meta_q;
      end
    end
    assign q_o[g] = sync_q;
  end
endmodule

// *** logic/tfhp_wr_path.sv ***
// Write character path: line reordering and internal odd parity
module tfhp_wr_path (
  input wire logic clk_i,
  input wire logic rst_n_i,
  tfhp_wr_if.path w
);
  logic [7:0] ord;
  genvar g;
  // Highest numbered line is the character's least significant bit
  for (g = 0; g < 8; g++) begin : g_rev
    assign ord[g] = w.raw_byte[7-g];
  end

  // Character and parity captured on each strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      w.char_q <= 8'h00;
      w.par_q <= 1'b1;
      w.par_err <= 1'b0;
      w.vld <= 1'b0;
    end else begin
      w.vld <= w.strobe;
      if (w.strobe) begin
        w.char_q <= ord;
        w.par_q <= ~^ord;
        w.par_err <= w.pchk_en && (w.host_par != ~^ord);
      end else begin
        w.par_err <= 1'b0;
      end
    end
  end

  odd_par_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    w.vld |-> ^{w.char_q, w.par_q}) else $error("stored parity not odd");
  bit_order_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    w.strobe |=> w.char_q[0] == $past(w.raw_byte[7])) else $error("line order wrong");
endmodule

// *** sim/tfhp_host_model.sv ***
// Host controller model: open collector readback and write character feed
module tfhp_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [31:0] rec_i,
  input wire logic [5:0] oe_i,
  output logic [5:0] lvl_o,
  output logic [7:0] data_n_o,
  output logic last_n_o,
  output logic par_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int idx_q;
  logic [7:0] chr;
  logic on;
  // Released lines float up to false through the terminators
  assign lvl_o = ~oe_i;
  // Step to the next character on each strobe, well before the next tick
  always_ff @(posedge clk_i) begin
    if (!go_i) begin
      idx_q <= 0;
    end else if (oe_i[3]) begin
      idx_q <= idx_q + 1;
    end
  end
  // Line k carries bit 7-k; outside the record every line is released
  always_comb begin
    on = go_i && (idx_q < 4);
    chr = on ? rec_i[8*idx_q[1:0] +: 8] : 8'h00;
    for (int k = 0; k < 8; k++) begin
      data_n_o[k] = ~chr[7-k];
    end
    par_n_o = ~(on && ~^chr);
    last_n_o = ~(go_i && idx_q == 3);
  end
endmodule

// *** sim/tfhp_top_tb.sv ***
// Self-checking bench of the tape formatter host port
module tfhp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr, rd, go, fast_n, lgap_n, chen_n, loaded, atlp, ld_done, ul_done;
  logic stopped, inch, chtick, bdone, corr, blank, last_n, par_n, wpar, vld;
  logic run, rewind, unload, load, fast;
  logic [7:0] addr, data_n, wchar;
  logic [31:0] wdata, rdata, rec;
  logic [3:0] pin_n, drop;
  logic [4:0] cmd_n, cmd;
  logic [2:0] unit_n;
  logic [5:0] fault, lvl, oe;
  logic [11:0] mon;
  int n_errors, total_checks, n_strb;
  assign mon = {fast, run, rewind, unload, load, vld, oe};
  tfhp_top dut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .INITIATE_N_I(pin_n[0]), .DIR_REVERSE_N_I(cmd_n[4]),
    .WRITE_SELECT_N_I(cmd_n[3]), .FILE_MARK_SELECT_N_I(cmd_n[2]), .EDIT_SELECT_N_I(cmd_n[1]),
    .ERASE_SELECT_N_I(cmd_n[0]), .FAST_SPEED_REQ_N_I(fast_n), .LONG_GAP_REQ_N_I(lgap_n),
    .REWIND_PULSE_N_I(pin_n[1]), .UNLOAD_PULSE_N_I(pin_n[2]), .LOAD_ONLINE_PULSE_N_I(pin_n[3]),
    .LAST_CHAR_FLAG_N_I(last_n), .CHAIN_ENABLE_N_I(chen_n), .UNIT_ADDR_HIGH_N_I(unit_n[2]),
    .UNIT_ADDR_MID_N_I(unit_n[1]), .UNIT_ADDR_LOW_N_I(unit_n[0]), .WRITE_PARITY_N_I(par_n),
    .WRITE_BYTE_LINES_N_I(data_n), .PIN_LVL_I(lvl), .PIN_DRV_O(), .PIN_OE_O(oe),
    .TAPE_LOADED_I(loaded), .AT_LOAD_POINT_I(atlp), .LOAD_DONE_I(ld_done),
    .UNLOAD_DONE_I(ul_done), .MOTION_STOPPED_I(stopped), .INCH_TICK_I(inch),
    .CHAR_TICK_I(chtick), .BLOCK_DONE_I(bdone), .FAULT_EVT_I(fault), .CORR_EVT_I(corr),
    .DROP_TRACKS_I(drop), .BLANK_25FT_I(blank), .MOTION_RUN_O(run), .MOTION_REV_O(),
    .FAST_MODE_O(fast), .REPOSITION_O(), .LONG_GAP_O(), .REWIND_O(rewind), .UNLOAD_O(unload),
    .LOAD_O(load), .CMD_O(cmd), .WCHAR_O(wchar), .WPAR_O(wpar), .WCHAR_VLD_O(vld));
  tfhp_host_model host (.clk_i(clk), .go_i(go), .rec_i(rec), .oe_i(oe), .lvl_o(lvl),
    .data_n_o(data_n), .last_n_o(last_n), .par_n_o(par_n));
  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Strobe pulses counted straight off the open collector enable
  always @(posedge clk) begin
    if (oe[3] === 1'b1) n_strb <= n_strb + 1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Bounded wait on one watched output, judged between clock edges
  task automatic wt(input string s, input int b, input logic v, input int n);
    for (int i = 0; i < n && mon[b] !== v; i++) @(negedge clk);
    chk(s, {31'h0, v}, {31'h0, mon[b]});
    tick(1);
  endtask
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    tick(1);
    wr <= 1'b0;
    tick(1);
  endtask
  task automatic br(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    tick(1);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
    tick(1);
  endtask
  // Cable pulses are held for several clocks so the synchroniser sees them
  task automatic pulse(input int i);
    pin_n[i] <= 1'b0;
    tick(4);
    pin_n[i] <= 1'b1;
    tick(1);
  endtask
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #50000;
    n_errors++;
    end_sim();
  end
  initial begin
    {rst_n, wr, rd, go, chtick, bdone, corr, blank, atlp, ld_done, ul_done, stopped} = '0;
    {fast_n, lgap_n, inch, loaded, chen_n} = 5'b11010;
    {addr, wdata, rec, drop, fault, n_strb} = '0;
    {pin_n, cmd_n, unit_n} = '1;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    br(tfhp_pkg::CFG_OFS, 32'h1000);
    br(8'h0c, 32'h0);
    bw(tfhp_pkg::CFG_OFS, 32'h1005);
    br(tfhp_pkg::CFG_OFS, 32'h1005);
    // Load pulse to unit 4 is not ours; unit 5 goes on line at once
    unit_n <= ~3'd4;
    pulse(3);
    tick(8);
    wt("foreign", 5, 1'b0, 1);
    unit_n <= ~3'd5;
    pulse(3);
    wt("online", 5, 1'b1, 10);
    // Write a four character record with a fault and a dropout on the way
    rec <= 32'h81c35a3c;
    go <= 1'b1;
    cmd_n <= ~tfhp_pkg::CMD_WRITE;
    pulse(0);
    wt("fby", 0, 1'b1, 10);
    wt("dby", 1, 1'b1, 4);
    cmd_n <= 5'h1f;
    n_strb <= 0;
    for (int i = 0; i < 4; i++) begin
      chtick <= 1'b1;
      tick(1);
      chtick <= 1'b0;
      wt("vld", 6, 1'b1, 6);
      chk("char", {24'h0, rec[8*i +: 8]}, {24'h0, wchar});
      chk("par", {31'h0, ~^rec[8*i +: 8]}, {31'h0, wpar});
      if (i == 1) fault <= 6'h01;
      if (i == 2) drop <= tfhp_pkg::DROP_WR_MIN;
      tick(1);
      fault <= 6'h00;
      drop <= 4'h0;
      if (i == 1 || i == 2) wt("hard", 2, 1'b1, 6);
      tick(12);
    end
    wt("dby end", 1, 1'b0, 8);
    chk("strobes", 32'd4, n_strb);
    chk("cmd", {27'h0, tfhp_pkg::CMD_WRITE}, {27'h0, cmd});
    br(tfhp_pkg::CMD_OFS, {27'h0, tfhp_pkg::CMD_WRITE});
    wt("fby held", 0, 1'b1, 1);
    stopped <= 1'b1;
    go <= 1'b0;
    wt("fby end", 0, 1'b0, 10);
    // Read ended by end of block, then a second read cut off by disable
    pulse(0);
    wt("rd dby", 1, 1'b1, 10);
    bdone <= 1'b1;
    tick(1);
    bdone <= 1'b0;
    wt("rd dby end", 1, 1'b0, 6);
    wt("rd fby end", 0, 1'b0, 6);
    pulse(0);
    wt("rd2 dby", 1, 1'b1, 10);
    chen_n <= 1'b1;
    wt("abort dby", 1, 1'b0, 8);
    wt("abort run", 10, 1'b0, 8);
    wt("quiet fby", 0, 1'b0, 8);
    chen_n <= 1'b0;
    // Inverted enable polarity makes a low line mean disabled
    bw(tfhp_pkg::CFG_OFS, 32'h100d);
    pulse(0);
    tick(8);
    wt("inv pol", 1, 1'b0, 1);
    // Capture mode: a corrected event inside the block outlives data busy
    bw(tfhp_pkg::CFG_OFS, 32'h1025);
    pulse(0);
    wt("cap dby", 1, 1'b1, 10);
    corr <= 1'b1;
    tick(1);
    corr <= 1'b0;
    bdone <= 1'b1;
    tick(1);
    bdone <= 1'b0;
    wt("cap dby end", 1, 1'b0, 6);
    wt("cap hard", 2, 1'b1, 1);
    bw(tfhp_pkg::CFG_OFS, 32'h1005);
    // Fast request follows the line on the selected on-line unit
    fast_n <= 1'b0;
    wt("fast", 11, 1'b1, 6);
    fast_n <= 1'b1;
    wt("slow", 11, 1'b0, 6);
    // Rewind keeps formatter idle and ready false until load point
    pulse(1);
    wt("rewind", 9, 1'b1, 10);
    wt("rew fby", 0, 1'b0, 1);
    wt("rew rdy", 4, 1'b0, 1);
    atlp <= 1'b1;
    wt("rew done", 9, 1'b0, 10);
    wt("ready", 4, 1'b1, 6);
    // Unload: off line at once, rewind, unload, then a full load sequence
    atlp <= 1'b0;
    pulse(2);
    wt("offline", 5, 1'b0, 6);
    wt("unl rew", 9, 1'b1, 6);
    atlp <= 1'b1;
    wt("unloading", 8, 1'b1, 10);
    loaded <= 1'b0;
    ul_done <= 1'b1;
    wt("unl done", 8, 1'b0, 10);
    pulse(3);
    wt("loading", 7, 1'b1, 10);
    loaded <= 1'b1;
    ld_done <= 1'b1;
    wt("reload", 5, 1'b1, 10);
    end_sim();
  end
endmodule
